/* File: verilog/slatch_pkg.sv */
// strap pin latch: shared constants for register map, strap layout and timing
`default_nettype none
package slatch_pkg;
	// ------------------------------------------------------------
	// strap bit positions within the captured word
	// ------------------------------------------------------------
	localparam int STRAP_W = 6; // six strap inputs
	localparam int STRAP_LDO = 0; // ldo_select_strap
	localparam int STRAP_BOOT_SEL = 1; // boot_select_strap
	localparam int STRAP_BOOT_AUX = 2; // boot_aux_strap
	localparam int STRAP_LOG_TIMING = 3; // log_timing_strap
	localparam int STRAP_SDIO_EDGE = 4; // sdio_edge_strap
	localparam int STRAP_SPARE = 5; // sixth strap, latched and readable only
	// pull direction per strap while held in reset: 1 = pull-up, 0 = pull-down
	localparam logic [5:0] STRAP_PULL_UP = 6'h1a;
	// ------------------------------------------------------------
	// register byte offsets (one aligned 32-bit word each)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_STRAP_CAPTURE = 4'h0; // read only
	localparam logic [3:0] REG_BOOT_CTRL = 4'h4; // read/write
	localparam logic [3:0] REG_BOOT_STATUS = 4'h8; // read only
	// boot control fields
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int CTRL_BOOT_DONE = 0;
	localparam int CTRL_LDO_OVR_EN = 1;
	localparam int CTRL_LDO_OVR_1V8 = 2;
	localparam int CTRL_SDIO_OVR_EN = 3;
	localparam int CTRL_SDIO_IN_RISE = 4;
	localparam int CTRL_SDIO_OUT_RISE = 5;
	// boot status fields
	localparam int STAT_FLASH_BOOT = 0;
	localparam int STAT_DOWNLOAD = 1;
	localparam int STAT_INVALID = 2;
	localparam int STAT_LOG_EN = 3;
	localparam int STAT_VDD_1V8 = 4;
	localparam int STAT_SDIO_IN_RISE = 5;
	localparam int STAT_SDIO_OUT_RISE = 6;
	localparam int STAT_RUNNING = 7;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100; // 10 mhz system clock
	localparam int STRAP_SETTLE_NS = 400; // pull settle time before sampling
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SLATCH_HOLD, SLATCH_CAPTURE, SLATCH_RUN} slatch_state_e;
endpackage
`default_nettype wire

/* File: verilog/slatch_top.sv */
// strap pin latch: capture, pulls, boot decode and avalon-mm register slave
// Summary of operation
// - sample six straps at reset, hold them
// - captured straps readable through capture register
// - weak default pulls on straps during reset
// - release straps afterwards; latches ignore pins
// - ldo strap 0 gives 3.3v, 1 1.8v
// - boot select 1 flash; both 0 download
// - log and sdio straps pick sdio edges
// - firmware may override vdd and sdio edges
// - device runs only while chip enable high
`timescale 1ns/10ps
`default_nettype none
module slatch_top #(
	parameter int SETTLE_CYCLES = slatch_pkg::STRAP_SETTLE_CYC
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic chip_en_i, // asynchronous pin, active high
	input wire logic [5:0] strap_pin_i, // raw strap pin levels
	output logic [5:0] strap_pull_en_o, // weak pull enable per strap
	output logic [5:0] strap_pull_up_o, // pull direction per strap
	input wire logic [5:0] func_out_i, // normal pin function drive value
	input wire logic [5:0] func_oe_i, // normal pin function drive enable
	output logic [5:0] strap_pin_o,
	output logic [5:0] strap_pin_oe_o, // high while the pin is driven
	input wire logic uart_tx_i, // console tx from the boot logic
	output logic console_uart_tx_o,
	output logic flash_vdd_1v8_o, // 1 = 1.8 v, 0 = 3.3 v
	output logic boot_from_flash_o,
	output logic download_boot_o,
	output logic sdio_in_rising_o,
	output logic sdio_out_rising_o,
	output logic device_running_o,
	input wire logic [3:0] avs_address_i, // byte address
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the settle counter is eight bits wide
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
	begin : g_bad_settle
		$error("SETTLE_CYCLES out of range");
	end

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic [5:0] strap_s1_r; // first stage, read only by second stage
	logic [5:0] strap_s2_r;
	logic en_s1_r; // first stage, read only by second stage
	logic en_s2_r;

	// pins come from outside the clock domain: two flops each
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_s1_r <= 6'h00;
			strap_s2_r <= 6'h00;
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
		end
		else
		begin
			strap_s1_r <= strap_pin_i;
			strap_s2_r <= strap_s1_r;
			en_s1_r <= chip_en_i;
			en_s2_r <= en_s1_r;
		end
	end

	// ------------------------------------------------------------
	// capture sequencer
	// ------------------------------------------------------------
	slatch_pkg::slatch_state_e state_r, state_nxt;
	logic [7:0] settle_r, settle_nxt; // cycles waited with pulls on
	logic [5:0] strap_r, strap_nxt; // latched strap bits

	// strap is sampled once pulls and synchroniser have settled
	always_comb
	begin
		state_nxt = state_r;
		settle_nxt = settle_r;
		strap_nxt = strap_r;
		unique case (state_r)
			slatch_pkg::SLATCH_HOLD:
			begin
				// chip enable low keeps the device held off
				if (!en_s2_r)
					settle_nxt = 8'h00;
				else if (settle_r == 8'(SETTLE_CYCLES - 1))
					state_nxt = slatch_pkg::SLATCH_CAPTURE;
				else
					settle_nxt = settle_r + 8'h01;
			end
			slatch_pkg::SLATCH_CAPTURE:
			begin
				strap_nxt = strap_s2_r;
				state_nxt = en_s2_r ? slatch_pkg::SLATCH_RUN : slatch_pkg::SLATCH_HOLD;
				settle_nxt = 8'h00;
			end
			slatch_pkg::SLATCH_RUN:
			begin
				// pins now free; strap_r is never reloaded here
				if (!en_s2_r)
					state_nxt = slatch_pkg::SLATCH_HOLD;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_r <= slatch_pkg::SLATCH_HOLD;
			settle_r <= 8'h00;
			strap_r <= 6'h00;
		end
		else
		begin
			state_r <= state_nxt;
			settle_r <= settle_nxt;
			strap_r <= strap_nxt;
		end
	end

	// ------------------------------------------------------------
	// register slave
	// ------------------------------------------------------------
	logic [5:0] ctrl_r, ctrl_nxt; // boot control register
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] status_w; // live boot status
	logic req_w;
	logic commit_w; // write takes effect here

	assign req_w = avs_read_i | avs_write_i;
	assign commit_w = avs_write_i & ~wait_r;

	// one wait cycle per access: data is prepared while waitrequest is high
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		rdata_nxt = rdata_r;
		wait_nxt = 1'b1;
		if (req_w && wait_r)
		begin
			wait_nxt = 1'b0;
			rdata_nxt = 32'h0000_0000; // unmapped reads give zero
			unique case (avs_address_i)
				slatch_pkg::REG_STRAP_CAPTURE: rdata_nxt = {26'h0, strap_r};
				slatch_pkg::REG_BOOT_CTRL: rdata_nxt = {26'h0, ctrl_r};
				slatch_pkg::REG_BOOT_STATUS: rdata_nxt = {24'h0, status_w};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		// only lane 0 holds bits; other lanes are ignored
		if (commit_w && avs_address_i == slatch_pkg::REG_BOOT_CTRL && avs_byteenable_i[0])
			ctrl_nxt = avs_writedata_i[5:0];
		// shutdown clears firmware settings; strap_r keeps its value until the next capture
		if (state_r == slatch_pkg::SLATCH_HOLD)
			ctrl_nxt = slatch_pkg::CTRL_RESET;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_r <= slatch_pkg::CTRL_RESET;
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// decode and pin outputs
	// ------------------------------------------------------------
	logic run_w, boot_done_w, log_en_w, ldo_ovr_w, sdio_ovr_w;
	logic vdd_1v8_w, in_rise_w, out_rise_w, flash_w, dl_w;
	logic [5:0] pull_en_nxt, pin_nxt, pin_oe_nxt;
	logic tx_nxt;

	assign run_w = (state_r == slatch_pkg::SLATCH_RUN);
	assign boot_done_w = ctrl_r[slatch_pkg::CTRL_BOOT_DONE];
	assign log_en_w = strap_r[slatch_pkg::STRAP_LOG_TIMING];
	// overrides only count once firmware has declared boot finished
	assign ldo_ovr_w = boot_done_w & ctrl_r[slatch_pkg::CTRL_LDO_OVR_EN];
	assign sdio_ovr_w = boot_done_w & ctrl_r[slatch_pkg::CTRL_SDIO_OVR_EN];
	// ldo strap: 1 selects 1.8 v, 0 the 3.3 v level
	assign vdd_1v8_w = ldo_ovr_w ? ctrl_r[slatch_pkg::CTRL_LDO_OVR_1V8] :
		strap_r[slatch_pkg::STRAP_LDO];
	// log strap picks input edge, sdio strap picks output edge
	assign in_rise_w = sdio_ovr_w ? ctrl_r[slatch_pkg::CTRL_SDIO_IN_RISE] :
		strap_r[slatch_pkg::STRAP_LOG_TIMING];
	assign out_rise_w = sdio_ovr_w ? ctrl_r[slatch_pkg::CTRL_SDIO_OUT_RISE] :
		strap_r[slatch_pkg::STRAP_SDIO_EDGE];
	// select 0 with aux 1 is no valid mode: neither boot path starts
	assign flash_w = strap_r[slatch_pkg::STRAP_BOOT_SEL];
	assign dl_w = ~strap_r[slatch_pkg::STRAP_BOOT_SEL] &
		~strap_r[slatch_pkg::STRAP_BOOT_AUX];
	assign status_w = {run_w, out_rise_w, in_rise_w, vdd_1v8_w, log_en_w,
		~flash_w & ~dl_w, dl_w, flash_w};

	// pull and pin outputs are registered from next state so they track it without lag
	always_comb
	begin
		// pulls stay on until the device leaves reset
		pull_en_nxt = (state_nxt == slatch_pkg::SLATCH_RUN) ? 6'h00 : 6'h3f;
		// the pin is never driven while its level is being sampled
		pin_oe_nxt = (state_nxt == slatch_pkg::SLATCH_RUN) ? func_oe_i : 6'h00;
		pin_nxt = (state_nxt == slatch_pkg::SLATCH_RUN) ? func_out_i : 6'h00;
		// silent means idle high, so a listener sees no start bit
		tx_nxt = (run_w && (boot_done_w || log_en_w)) ? uart_tx_i : 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			strap_pull_en_o <= 6'h3f;
			strap_pull_up_o <= slatch_pkg::STRAP_PULL_UP;
			strap_pin_o <= 6'h00;
			strap_pin_oe_o <= 6'h00;
			console_uart_tx_o <= 1'b1;
			flash_vdd_1v8_o <= 1'b0;
			boot_from_flash_o <= 1'b0;
			download_boot_o <= 1'b0;
			sdio_in_rising_o <= 1'b0;
			sdio_out_rising_o <= 1'b0;
			device_running_o <= 1'b0;
		end
		else
		begin
			strap_pull_en_o <= pull_en_nxt;
			strap_pull_up_o <= slatch_pkg::STRAP_PULL_UP;
			strap_pin_o <= pin_nxt;
			strap_pin_oe_o <= pin_oe_nxt;
			console_uart_tx_o <= tx_nxt;
			flash_vdd_1v8_o <= vdd_1v8_w;
			boot_from_flash_o <= run_w & flash_w;
			download_boot_o <= run_w & dl_w;
			sdio_in_rising_o <= in_rise_w;
			sdio_out_rising_o <= out_rise_w;
			device_running_o <= run_w;
		end
	end
	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = wait_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_capture;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		state_r == slatch_pkg::SLATCH_CAPTURE |=> strap_r == $past(strap_s2_r);
	endproperty
	a_capture: assert property (p_capture) else $error("strap not captured");

	property p_readback;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		avs_read_i && wait_r && avs_address_i == slatch_pkg::REG_STRAP_CAPTURE
		|=> !avs_waitrequest_o && avs_readdata_o == {26'h0, $past(strap_r)};
	endproperty
	a_readback: assert property (p_readback) else $error("capture readback wrong");

	property p_pulls;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		state_r != slatch_pkg::SLATCH_RUN |-> strap_pull_en_o == 6'h3f && strap_pin_oe_o == 6'h00;
	endproperty
	a_pulls: assert property (p_pulls) else $error("pulls off or pin driven in reset");

	property p_latch_stable;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		run_w ##1 run_w |-> $stable(strap_r) && strap_pull_en_o == 6'h00;
	endproperty
	a_latch_stable: assert property (p_latch_stable) else $error("latch moved in run");

	property p_ldo;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		!ldo_ovr_w |=> flash_vdd_1v8_o == $past(strap_r[slatch_pkg::STRAP_LDO]);
	endproperty
	a_ldo: assert property (p_ldo) else $error("vdd select wrong");

	property p_boot;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		run_w |=> boot_from_flash_o == $past(strap_r[slatch_pkg::STRAP_BOOT_SEL])
			&& download_boot_o == ($past(strap_r[2:1]) == 2'h0);
	endproperty
	a_boot: assert property (p_boot) else $error("boot mode wrong");

	property p_log_silent;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		!boot_done_w && !log_en_w |=> console_uart_tx_o;
	endproperty
	a_log_silent: assert property (p_log_silent) else $error("console not silent");

	property p_sdio;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		!sdio_ovr_w |=> {sdio_in_rising_o, sdio_out_rising_o}
			== {$past(strap_r[slatch_pkg::STRAP_LOG_TIMING]), $past(strap_r[slatch_pkg::STRAP_SDIO_EDGE])};
	endproperty
	a_sdio: assert property (p_sdio) else $error("sdio edges wrong");

	property p_override;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		ldo_ovr_w |=> flash_vdd_1v8_o == $past(ctrl_r[slatch_pkg::CTRL_LDO_OVR_1V8]);
	endproperty
	a_override: assert property (p_override) else $error("vdd override ignored");

	property p_enable;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		!en_s2_r |=> state_r == slatch_pkg::SLATCH_HOLD ##1 !device_running_o;
	endproperty
	a_enable: assert property (p_enable) else $error("ran with enable low");

	property p_wait;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		req_w && wait_r |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
endmodule
`default_nettype wire

/* File: test/slatch_strap_host.sv */
// strap host model: weak pulls, host gpios and floating pins on the straps
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// pin resolution for the six strap pins
// ------------------------------------------------------------
module slatch_strap_host (
	input wire logic clk_i,
	input wire logic host_en_i, // host gpios drive the straps
	input wire logic [5:0] host_val_i, // wanted strap levels
	input wire logic [5:0] pull_en_i, // device weak pull enable
	input wire logic [5:0] pull_up_i, // device pull direction
	input wire logic [5:0] pin_i, // device drive value
	input wire logic [5:0] pin_oe_i, // device drive enable
	output logic [5:0] pin_o // level seen on each pin
);
	logic [5:0] float_r = 6'h00; // undriven level, never a stale value
	// toggle each cycle so a floating pin cannot pass for a held level
	always @(posedge clk_i)
	begin
		float_r <= ~float_r;
	end
	// device drive wins, then the host, then the weak pull
	always_comb
	begin
		for (int b = 0; b < 6; b++)
		begin
			if (pin_oe_i[b])
				pin_o[b] = pin_i[b];
			else if (host_en_i)
				pin_o[b] = host_val_i[b];
			else if (pull_en_i[b])
				pin_o[b] = pull_up_i[b];
			else
				pin_o[b] = float_r[b];
		end
	end
endmodule
`default_nettype wire

/* File: test/slatch_top_bench.sv */
// self-checking bench for the strap latch, its register bus and strap host
`timescale 1ns/10ps
`default_nettype none
module slatch_top_bench;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic resetn = 1'b0; // active low
	logic chip_en = 1'b0;
	logic host_en = 1'b0;
	logic [5:0] host_val = 6'h00;
	logic [5:0] func_out = 6'h00;
	logic [5:0] func_oe = 6'h00;
	logic uart_tx = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'h0;
	logic [5:0] pin, pull_en, pull_up, pin_out, pin_oe;
	logic tx, vdd, flash, dl, in_r, out_r, running, wait_req;
	logic [31:0] rdata;
	int errors = 0;
	int tests_run = 0;
	always #50 clk = ~clk; // 10 mhz
	slatch_top slatch_top_i (.sys_clk_i(clk), .resetn_i(resetn), .chip_en_i(chip_en),
		.strap_pin_i(pin), .strap_pull_en_o(pull_en), .strap_pull_up_o(pull_up),
		.func_out_i(func_out), .func_oe_i(func_oe), .strap_pin_o(pin_out),
		.strap_pin_oe_o(pin_oe), .uart_tx_i(uart_tx), .console_uart_tx_o(tx),
		.flash_vdd_1v8_o(vdd), .boot_from_flash_o(flash), .download_boot_o(dl),
		.sdio_in_rising_o(in_r), .sdio_out_rising_o(out_r), .device_running_o(running),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req));
	slatch_strap_host slatch_strap_host_i (.clk_i(clk), .host_en_i(host_en),
		.host_val_i(host_val), .pull_en_i(pull_en), .pull_up_i(pull_up), .pin_i(pin_out),
		.pin_oe_i(pin_oe), .pin_o(pin));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// expected status word from straps s and control c
	function automatic logic [7:0] stat(input logic [5:0] s, input logic [5:0] c);
		logic [7:0] r;
		r[0] = s[1];
		r[1] = !s[1] && !s[2];
		r[2] = !s[1] && s[2];
		r[3] = s[3];
		r[4] = (c[0] && c[1]) ? c[2] : s[0]; // overrides only once booted
		r[5] = (c[0] && c[3]) ? c[4] : s[3];
		r[6] = (c[0] && c[3]) ? c[5] : s[4];
		r[7] = 1'b1;
		return r;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// one avalon access; holds the request until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		be <= e;
		n = 0;
		// waitrequest is sampled at the rising edge, before that edge updates it
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wait_req !== 1'b0 && n < 20);
		q = rdata; // read data stands in the cycle in which waitrequest is low
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20)
			chk(32'h1, 32'h0, "bus hang");
	endtask
	// straps held by host or pulls, enable raised, host let go after capture
	task power_up(input logic drive, input logic [5:0] v, input logic use_rst);
		int n;
		@(posedge clk);
		host_en <= drive;
		host_val <= v;
		chip_en <= 1'b0;
		resetn <= !use_rst;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk(32'({pull_en, pull_up}), 32'h00000fda, "pulls held");
		chk(32'({running, pin_oe}), 32'h0, "held off");
		@(posedge clk);
		resetn <= 1'b1;
		chip_en <= 1'b1;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (running !== 1'b1 && n < 40);
		chk(32'(running), 32'h1, "start");
		@(posedge clk);
		host_en <= 1'b0;
	endtask
	// console tx must follow uart_tx one cycle late or stay idle high
	task tx_check(input logic pass);
		logic prev;
		logic cur;
		cur = 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			@(posedge clk);
			prev = cur;
			cur = 1'($urandom);
			uart_tx <= cur;
			@(negedge clk);
			if (i > 0)
				chk(32'(tx), 32'(pass ? prev : 1'b1), "console tx");
		end
	endtask
	// normal pin functions pass through with one cycle of delay
	task pin_check;
		logic [5:0] po;
		logic [5:0] pe;
		logic [5:0] fo;
		logic [5:0] fe;
		fo = 6'h00;
		fe = 6'h00;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			po = fo;
			pe = fe;
			fo = 6'($urandom);
			fe = 6'($urandom);
			func_out <= fo;
			func_oe <= fe;
			@(negedge clk);
			if (i > 0)
				chk(32'({pin_oe, pin_out}), 32'({pe, po}), "pin path");
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence: random and corner straps, reset and enable cycles
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		logic [5:0] s;
		logic [5:0] v;
		logic [5:0] c;
		logic [7:0] x;
		q = $urandom(38);
		for (int t = 0; t < 10; t++)
		begin
			v = 6'($urandom);
			if (t > 0 && t < 5)
				v[2:1] = 2'(t - 1); // every boot select and aux pair
			s = (t == 0) ? 6'h1a : v; // undriven straps settle to the pull defaults
			power_up(t != 0, v, !t[0]); // odd tests re-enable without reset
			bus(1'b0, 4'h0, 32'h0, 4'hf, q);
			chk(q, 32'(s), "capture");
			bus(1'b0, 4'h4, 32'h0, 4'hf, q);
			chk(q, 32'h0, "ctrl after start");
			x = stat(s, 6'h00);
			chk(32'({out_r, in_r, vdd, dl, flash}), 32'({x[6:4], x[1:0]}), "decode");
			chk(32'(pull_en), 32'h0, "pulls off");
			bus(1'b0, 4'h8, 32'h0, 4'hf, q);
			chk(q, 32'(x), "status");
			pin_check();
			bus(1'b0, 4'h0, 32'h0, 4'hf, q);
			chk(q, 32'(s), "latch kept");
			c = 6'($urandom);
			c[0] = t[0];
			bus(1'b1, 4'h4, 32'(c), 4'hf, q);
			bus(1'b1, 4'h4, 32'(~c), 4'he, q);
			bus(1'b1, 4'h0, 32'(~s), 4'hf, q);
			bus(1'b0, 4'hc, 32'h0, 4'hf, q);
			chk(q, 32'h0, "unmapped");
			bus(1'b0, 4'h4, 32'h0, 4'hf, q);
			chk(q, 32'(c), "ctrl");
			repeat (2) @(negedge clk);
			x = stat(s, c);
			chk(32'({out_r, in_r, vdd, dl, flash}), 32'({x[6:4], x[1:0]}), "override");
			bus(1'b0, 4'h0, 32'h0, 4'hf, q);
			chk(q, 32'(s), "ro capture");
			tx_check(s[3] | c[0]);
			$display("test %0d done", t);
		end
		complete_run();
	end
	// watchdog well beyond the several hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		complete_run();
	end
endmodule
`default_nettype wire
